//--- verilog/lds_pkg.sv
// Shared constants for the LED driver two-wire slave and its bus master.
// Assumes both ends run on the same 10 MHz pclk and share the wired-AND link.
`default_nettype none
package lds_pkg;
   // Clock and link timing
   localparam int                   LDS_CLK_NS       = 100;
   localparam int                   LDS_SCL_MAX_KHZ  = 3400;
   localparam int                   LDS_SCL_QTR_NS   = 400;
   localparam int                   LDS_QTR_CYC      = (LDS_SCL_QTR_NS + LDS_CLK_NS - 1) / LDS_CLK_NS;
   localparam int                   LDS_DIV_W        = 3;
   localparam logic [LDS_DIV_W-1:0] LDS_QTR_LAST     = LDS_DIV_W'(LDS_QTR_CYC - 1);
   localparam logic [3:0]           LDS_BYTE_BITS    = 4'h8;
   // Device register file
   localparam int                   LDS_NREG         = 32;
   localparam logic [6:0]           LDS_PRESET_ADDR  = 7'h00;
   localparam logic [7:0]           LDS_BANK_MASK    = 8'he0;
   localparam logic [4:0]           LDS_IDX_SHUTDOWN = 5'h0c;
   localparam logic [4:0]           LDS_IDX_FEATURE  = 5'h0e;
   localparam logic [7:0]           LDS_CMD_SELF_ADDR = 8'h2d;
   localparam int                   LDS_SD_MODE_BIT  = 0;
   localparam int                   LDS_SD_KEEP_BIT  = 7;
   localparam logic [7:0]           LDS_SD_RESET_VAL = 8'h00;
   localparam logic [7:0]           LDS_FEATURE_DEFAULT = 8'h00;
   // Master APB map and fields
   localparam logic [7:0]           LDS_APB_CMD      = 8'h00;
   localparam logic [7:0]           LDS_APB_STATUS   = 8'h04;
   localparam int                   LDS_CR_ADDR_LSB  = 0;
   localparam int                   LDS_CR_RW_BIT    = 7;
   localparam int                   LDS_CR_CMD_LSB   = 8;
   localparam int                   LDS_CR_WDATA_LSB = 16;
   localparam int                   LDS_CR_GO_BIT    = 24;
   localparam int                   LDS_ST_BUSY_BIT  = 0;
   localparam int                   LDS_ST_NACK_BIT  = 1;
   localparam int                   LDS_ST_RDATA_LSB = 8;
   // Master byte slots within one transfer
   localparam logic [2:0]           LDS_BI_ADDR_W    = 3'h0;
   localparam logic [2:0]           LDS_BI_CMD       = 3'h1;
   localparam logic [2:0]           LDS_BI_WDATA     = 3'h2;
   localparam logic [2:0]           LDS_BI_ADDR_R    = 3'h3;
   localparam logic [2:0]           LDS_BI_RDATA     = 3'h4;
endpackage
`default_nettype wire

//--- verilog/lds_i2c_if.sv
// Two-wire link between the bus master and the LED driver slave.
// Assumes open-drain pins with pull-ups; levels are the wired-AND of all drivers.
`timescale 1ns/1ps
`default_nettype none
interface lds_i2c_if;
   logic scl;
   logic sda;
   logic host_scl_o;
   logic host_scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;

   // Released lines float high through the pull-up
   assign scl = host_scl_oe_n | host_scl_o;
   assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

   modport dev (
      input  scl,
      input  sda,
      output dev_sda_o,
      output dev_sda_oe_n
   );

   modport host (
      input  scl,
      input  sda,
      output host_scl_o,
      output host_scl_oe_n,
      output host_sda_o,
      output host_sda_oe_n
   );
endinterface
`default_nettype wire

//--- verilog/lds_slave.sv
// Slave end of the LED driver two-wire link with its register file and shutdown.
// Assumes link levels sampled on pclk, with SCL well below pclk/8.
//
// The placing of the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module lds_slave
   import lds_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   lds_i2c_if.dev          link,
   input  wire logic       hw_shutdown_pin_n,
   input  wire logic       segment_g_line,
   input  wire logic       segment_f_line,
   output var  logic       normal_mode,
   output var  logic [7:0] feature_value,
   output var  logic [1:0] dev_select,
   output var  logic       link_active
);

   typedef enum logic [2:0] {D_IDLE, D_RX, D_RACK, D_TX, D_TACK} lds_dev_phase_type;
   typedef enum logic [1:0] {B_ADDR, B_CMD, B_DATA} lds_byte_type;

   typedef struct packed {
      logic                     scl_m;
      logic                     scl_s;
      logic                     scl_d;
      logic                     sda_m;
      logic                     sda_s;
      logic                     sda_d;
      logic                     pin_m;
      logic                     pin_s;
      logic                     g_m;
      logic                     g_s;
      logic                     f_m;
      logic                     f_s;
      lds_dev_phase_type        ph;
      lds_byte_type             bt;
      logic [3:0]               cnt;
      logic [7:0]               sh;
      logic [7:0]               cmd;
      logic                     rw;
      logic                     nack;
      logic [1:0]               sel;
      logic                     sda_o;
      logic                     sda_oe_n;
      logic                     active;
      logic [LDS_NREG-1:0][7:0] regs;
   } lds_dev_state_type;

   lds_dev_state_type r;
   lds_dev_state_type n;

   logic       rise_c;
   logic       fall_c;
   logic       start_c;
   logic       stop_c;
   logic [6:0] own_addr;
   logic [7:0] cmd_inc;
   logic [7:0] rd_cur;
   logic [7:0] rd_nxt;

   function automatic logic [7:0] rd_byte(input logic [7:0] c,
                                          input logic [LDS_NREG-1:0][7:0] rg);
      return ((c & LDS_BANK_MASK) == 8'h00) ? rg[c[4:0]] : 8'h00;
   endfunction

   // Edge and condition detection on the synchronised link levels
   assign rise_c   = r.scl_s & ~r.scl_d;
   assign fall_c   = ~r.scl_s & r.scl_d;
   assign start_c  = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
   assign stop_c   = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
   assign own_addr = {LDS_PRESET_ADDR[6:2], r.sel};
   assign cmd_inc  = r.cmd + 8'h01;
   assign rd_cur   = rd_byte(r.cmd, r.regs);
   assign rd_nxt   = rd_byte(cmd_inc, r.regs);

   always_comb begin
      n       = r;
      n.scl_m = link.scl;
      n.scl_s = r.scl_m;
      n.scl_d = r.scl_s;
      n.sda_m = link.sda;
      n.sda_s = r.sda_m;
      n.sda_d = r.sda_s;
      n.pin_m = hw_shutdown_pin_n;
      n.pin_s = r.pin_m;
      // Key-sense nodes are only synchronised, never debounced
      n.g_m   = segment_g_line;
      n.g_s   = r.g_m;
      n.f_m   = segment_f_line;
      n.f_s   = r.f_m;
      if (start_c) begin
         // A repeated START simply restarts address reception
         n.ph       = D_RX;
         n.bt       = B_ADDR;
         n.cnt      = 4'h0;
         n.sda_oe_n = 1'b1;
      end else if (stop_c) begin
         n.ph       = D_IDLE;
         n.sda_oe_n = 1'b1;
      end else begin
         case (r.ph)
            D_RX: begin
               if (rise_c && r.cnt != LDS_BYTE_BITS) begin
                  n.sh  = {r.sh[6:0], r.sda_s};
                  n.cnt = r.cnt + 4'h1;
               end else if (fall_c && r.cnt == LDS_BYTE_BITS) begin
                  n.cnt      = 4'h0;
                  n.sda_oe_n = 1'b0;
                  n.ph       = D_RACK;
                  case (r.bt)
                     B_ADDR: begin
                        if (r.sh[7:1] == own_addr) begin
                           n.rw = r.sh[0];
                           n.bt = B_CMD;
                        end else begin
                           n.sda_oe_n = 1'b1;
                           n.ph       = D_IDLE;
                        end
                     end
                     B_CMD: begin
                        n.cmd = r.sh;
                        n.bt  = B_DATA;
                        if (r.sh == LDS_CMD_SELF_ADDR) begin
                           n.sel = {r.f_s, r.g_s};
                        end
                     end
                     default: begin
                        if ((r.cmd & LDS_BANK_MASK) == 8'h00) begin
                           n.regs[r.cmd[4:0]] = r.sh;
                           // Feature reset only when the mode really changes
                           if (r.cmd[4:0] == LDS_IDX_SHUTDOWN &&
                               !r.sh[LDS_SD_KEEP_BIT] &&
                               r.sh[LDS_SD_MODE_BIT] !=
                               r.regs[LDS_IDX_SHUTDOWN][LDS_SD_MODE_BIT]) begin
                              n.regs[LDS_IDX_FEATURE] = LDS_FEATURE_DEFAULT;
                           end
                        end
                        n.cmd = cmd_inc;
                     end
                  endcase
               end
            end
            D_RACK: begin
               // Acknowledge is held from one falling edge to the next
               if (fall_c) begin
                  if (r.rw) begin
                     n.sh       = rd_cur;
                     n.sda_oe_n = rd_cur[7];
                     n.cnt      = 4'h1;
                     n.ph       = D_TX;
                  end else begin
                     n.sda_oe_n = 1'b1;
                     n.ph       = D_RX;
                  end
               end
            end
            D_TX: begin
               if (fall_c) begin
                  if (r.cnt == LDS_BYTE_BITS) begin
                     n.sda_oe_n = 1'b1;
                     n.ph       = D_TACK;
                  end else begin
                     n.sda_oe_n = r.sh[6];
                     n.sh       = {r.sh[6:0], 1'b0};
                     n.cnt      = r.cnt + 4'h1;
                  end
               end
            end
            D_TACK: begin
               if (rise_c) begin
                  n.nack = r.sda_s;
               end else if (fall_c) begin
                  if (r.nack) begin
                     n.ph = D_IDLE;
                  end else begin
                     n.cmd      = cmd_inc;
                     n.sh       = rd_nxt;
                     n.sda_oe_n = rd_nxt[7];
                     n.cnt      = 4'h1;
                     n.ph       = D_TX;
                  end
               end
            end
            default: begin
               n.ph = D_IDLE;
            end
         endcase
      end
      // Pin low acts as a write of the shutdown code with the keep bit clear
      if (!r.pin_s) begin
         if (n.regs[LDS_IDX_SHUTDOWN][LDS_SD_MODE_BIT]) begin
            n.regs[LDS_IDX_FEATURE] = LDS_FEATURE_DEFAULT;
         end
         n.regs[LDS_IDX_SHUTDOWN] = LDS_SD_RESET_VAL;
      end
      n.active = (n.ph != D_IDLE);
   end

   // All registers clear to zero: shutdown, one digit, no decode, least intensity
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r          <= '0;
         r.scl_m    <= 1'b1;
         r.scl_s    <= 1'b1;
         r.scl_d    <= 1'b1;
         r.sda_m    <= 1'b1;
         r.sda_s    <= 1'b1;
         r.sda_d    <= 1'b1;
         r.pin_m    <= 1'b1;
         r.pin_s    <= 1'b1;
         r.sda_oe_n <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // The slave never drives SCL and only ever pulls SDA low
   assign link.dev_sda_o    = r.sda_o;
   assign link.dev_sda_oe_n = r.sda_oe_n;
   assign normal_mode       = r.regs[LDS_IDX_SHUTDOWN][LDS_SD_MODE_BIT];
   assign feature_value     = r.regs[LDS_IDX_FEATURE];
   assign dev_select        = r.sel;
   assign link_active       = r.active;

endmodule
`default_nettype wire

//--- verilog/lds_master.sv
// Bus master end of the LED driver link, ordered by software over APB.
// Assumes an APB master on pclk and the slave on the shared link interface.
`timescale 1ns/1ps
`default_nettype none
module lds_master
   import lds_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   lds_i2c_if.host          link,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr
);

   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} lds_host_phase_type;

   typedef struct packed {
      logic                 scl_m;
      logic                 scl_s;
      logic                 sda_m;
      logic                 sda_s;
      lds_host_phase_type   ph;
      logic [LDS_DIV_W-1:0] div;
      logic [1:0]           q;
      logic [3:0]           bc;
      logic [2:0]           bi;
      logic [7:0]           sh;
      logic [31:0]          creg;
      logic                 busy;
      logic                 nack;
      logic [7:0]           rdata;
      logic                 scl_o;
      logic                 scl_oe_n;
      logic                 sda_o;
      logic                 sda_oe_n;
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
   } lds_host_state_type;

   lds_host_state_type r;
   lds_host_state_type n;

   logic        tick;
   logic        rxbyte;
   logic [6:0]  addr7;
   logic [31:0] status;

   assign tick   = (r.div == LDS_QTR_LAST);
   assign rxbyte = (r.bi == LDS_BI_RDATA);
   assign addr7  = r.creg[LDS_CR_ADDR_LSB +: 7];

   always_comb begin
      status                            = 32'h0;
      status[LDS_ST_BUSY_BIT]           = r.busy;
      status[LDS_ST_NACK_BIT]           = r.nack;
      status[LDS_ST_RDATA_LSB +: 8]     = r.rdata;
   end

   always_comb begin
      n         = r;
      n.scl_m   = link.scl;
      n.scl_s   = r.scl_m;
      n.sda_m   = link.sda;
      n.sda_s   = r.sda_m;
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      if (psel && !penable) begin
         n.pready = 1'b1;
         if (paddr == LDS_APB_CMD) begin
            n.prdata = r.creg;
         end else if (paddr == LDS_APB_STATUS) begin
            n.prdata = status;
         end else begin
            n.prdata  = 32'h0;
            n.pslverr = 1'b1;
         end
      end
      // Orders written while busy are dropped
      if (psel && penable && r.pready && pwrite && paddr == LDS_APB_CMD && !r.busy) begin
         n.creg = pwdata;
         if (pwdata[LDS_CR_GO_BIT]) begin
            n.busy = 1'b1;
            n.nack = 1'b0;
            n.bi   = LDS_BI_ADDR_W;
         end
      end
      n.div = tick ? {LDS_DIV_W{1'b0}} : r.div + LDS_DIV_W'(1);
      if (tick) begin
         n.q = r.q + 2'h1;
         case (r.ph)
            H_START: begin
               case (r.q)
                  2'h0: n.scl_oe_n = 1'b0;
                  2'h1: n.sda_oe_n = 1'b1;
                  2'h2: n.scl_oe_n = 1'b1;
                  default: begin
                     n.sda_oe_n = 1'b0;
                     n.ph       = H_BIT;
                     n.bc       = 4'h0;
                     n.sh       = {addr7, r.bi == LDS_BI_ADDR_R};
                  end
               endcase
            end
            H_BIT: begin
               case (r.q)
                  2'h0: n.scl_oe_n = 1'b0;
                  2'h1: begin
                     // Data changes only while SCL is low
                     // Single read byte is the last, so it is not acknowledged
                     n.sda_oe_n = (r.bc == LDS_BYTE_BITS || rxbyte) ? 1'b1 : r.sh[7];
                  end
                  2'h2: n.scl_oe_n = 1'b1;
                  default: begin
                     if (r.bc != LDS_BYTE_BITS) begin
                        n.sh = {r.sh[6:0], r.sda_s};
                        n.bc = r.bc + 4'h1;
                     end else begin
                        n.bc = 4'h0;
                        if (!rxbyte && r.sda_s) begin
                           n.nack = 1'b1;
                           n.ph   = H_STOP;
                        end else if (r.bi == LDS_BI_ADDR_W) begin
                           n.bi = LDS_BI_CMD;
                           n.sh = r.creg[LDS_CR_CMD_LSB +: 8];
                        end else if (r.bi == LDS_BI_CMD && r.creg[LDS_CR_RW_BIT]) begin
                           n.bi = LDS_BI_ADDR_R;
                           n.ph = H_START;
                        end else if (r.bi == LDS_BI_CMD) begin
                           n.bi = LDS_BI_WDATA;
                           n.sh = r.creg[LDS_CR_WDATA_LSB +: 8];
                        end else if (r.bi == LDS_BI_ADDR_R) begin
                           n.bi = LDS_BI_RDATA;
                        end else begin
                           if (rxbyte) begin
                              n.rdata = r.sh;
                           end
                           n.ph = H_STOP;
                        end
                     end
                  end
               endcase
            end
            H_STOP: begin
               case (r.q)
                  2'h0: n.scl_oe_n = 1'b0;
                  2'h1: n.sda_oe_n = 1'b0;
                  2'h2: n.scl_oe_n = 1'b1;
                  default: begin
                     n.sda_oe_n = 1'b1;
                     n.ph       = H_IDLE;
                     n.busy     = 1'b0;
                  end
               endcase
            end
            default: begin
               n.q = 2'h0;
               if (r.busy && r.scl_s && r.sda_s) begin
                  n.ph = H_START;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r          <= '0;
         r.scl_m    <= 1'b1;
         r.scl_s    <= 1'b1;
         r.sda_m    <= 1'b1;
         r.sda_s    <= 1'b1;
         r.scl_oe_n <= 1'b1;
         r.sda_oe_n <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign link.host_scl_o    = r.scl_o;
   assign link.host_scl_oe_n = r.scl_oe_n;
   assign link.host_sda_o    = r.sda_o;
   assign link.host_sda_oe_n = r.sda_oe_n;
   assign prdata             = r.prdata;
   assign pready             = r.pready;
   assign pslverr            = r.pslverr;

endmodule
`default_nettype wire

//--- verif/lds_link_properties.sv
// Wire-level checks on the two-wire link between the master and slave ends.
// Assumes link levels change only just after rising pclk edges.
`timescale 1ns/1ps
`default_nettype none
module lds_link_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_oe_n
);
   logic       scl_r, sda_r, rd_r, ack_r, self_r, start, stop, rise, hi, ack0, ackn;
   logic [3:0] bit_r;
   logic [2:0] byte_r;
   logic [7:0] sh_r;
   assign start = scl_r & scl & sda_r & ~sda;
   assign stop  = scl_r & scl & ~sda_r & sda;
   assign rise  = scl & ~scl_r;
   assign hi    = scl & scl_r;
   assign ack0  = hi & (bit_r == 4'h9) & (byte_r == 3'h0);
   assign ackn  = hi & (bit_r == 4'h9) & (byte_r != 3'h0);
   // Bit and byte position since the last START
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {scl_r, sda_r, rd_r, ack_r, self_r} <= 5'h18;
         {bit_r, byte_r, sh_r} <= 15'h0000;
      end else begin
         scl_r <= scl;
         sda_r <= sda;
         if (start) begin
            {bit_r, byte_r, rd_r, ack_r} <= 9'h000;
         end else if (rise) begin
            bit_r <= (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
            if (bit_r == 4'h9) byte_r <= byte_r + 3'h1;
            if (bit_r != 4'h8) sh_r <= {sh_r[6:0], sda};
            if (bit_r == 4'h8 && byte_r == 3'h0) rd_r <= sh_r[0];
            if (bit_r == 4'h8 && byte_r == 3'h0) ack_r <= ~sda;
            if (bit_r == 4'h8 && byte_r == 3'h1 && ack_r && !rd_r && sh_r == 8'h2d) self_r <= 1'b1;
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_hold_high; hi |-> $stable(dev_sda_oe_n); endproperty
   property p_ack_low; rise && bit_r == 4'h8 && !dev_sda_oe_n |-> ##1 (!dev_sda_oe_n) [*7]; endproperty
   property p_no_match; ack0 && sh_r[7:3] != 5'h00 |-> dev_sda_oe_n; endproperty
   property p_preset; ack0 && sh_r[7:1] == 7'h00 && !self_r |-> !dev_sda_oe_n; endproperty
   property p_wr_ack; ackn && ack_r && !rd_r |-> !dev_sda_oe_n; endproperty
   property p_rx_free; hi && bit_r != 4'h9 && bit_r != 4'h0 && (byte_r == 3'h0 || !rd_r) |-> dev_sda_oe_n; endproperty
   property p_nack_free; rise && bit_r == 4'h8 && byte_r != 3'h0 && rd_r && sda |-> ##1 dev_sda_oe_n [*8]; endproperty
   property p_stop_free; stop |-> ##1 dev_sda_oe_n [*8]; endproperty
   a_hold_high: assert property (p_hold_high) else $error("sda moved, scl high");
   a_ack_low: assert property (p_ack_low) else $error("ack not held");
   a_no_match: assert property (p_no_match) else $error("ack to other address");
   a_preset: assert property (p_preset) else $error("preset address not acked");
   a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked");
   a_rx_free: assert property (p_rx_free) else $error("slave drove while receiving");
   a_nack_free: assert property (p_nack_free) else $error("sda kept after nack");
   a_stop_free: assert property (p_stop_free) else $error("sda driven after stop");
   c_restart: cover property (start && byte_r != 3'h0);
   c_read_nack: cover property (rise && bit_r == 4'h8 && rd_r && sda);
   c_self: cover property (ack0 && self_r);
endmodule
`default_nettype wire

//--- verif/led_driver_i2c_slave_shutdown_test.sv
// Bench: APB orders to the master end, the slave end answers over the link.
// Assumes both design ends and the link interface, on a 10 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
module led_driver_i2c_slave_shutdown_test;
   import lds_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, normal_mode;
   logic        hw_shutdown_pin_n, segment_g_line, segment_f_line, link_active;
   logic [7:0]  paddr, feature_value;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  dev_select;
   int          mismatches, checked;
   localparam logic [7:0] feat_cmd = {3'h0, LDS_IDX_FEATURE};
   lds_i2c_if link ();
   lds_master i_lds_master (.pclk(pclk), .presetn(presetn), .link(link), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   lds_slave i_lds_slave (.pclk(pclk), .presetn(presetn), .link(link),
      .hw_shutdown_pin_n(hw_shutdown_pin_n), .segment_g_line(segment_g_line),
      .segment_f_line(segment_f_line), .normal_mode(normal_mode),
      .feature_value(feature_value), .dev_select(dev_select), .link_active(link_active));
   lds_link_properties i_lds_link_properties (.pclk(pclk), .presetn(presetn),
      .scl(link.scl), .sda(link.sda), .dev_sda_oe_n(link.dev_sda_oe_n));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic complete_run();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic stall();
      mismatches++;
      $display("Error at %0t: wait ran out", $time);
      complete_run();
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; read data and error land in rd and err
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) stall();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Orders one link transfer, waits for idle and checks the nack flag
   task automatic xfer(input logic [6:0] a, input logic r, input logic [7:0] c,
                       input logic [7:0] w, input logic nk);
      int   n;
      logic seen;
      apb(1'b1, LDS_APB_CMD, {7'h00, 1'b1, w, c, r, a});
      n = 0;
      seen = 1'b0;
      do begin
         apb(1'b0, LDS_APB_STATUS, 32'h0);
         seen = seen | link_active;
         n++;
      end while (rd[LDS_ST_BUSY_BIT] !== 1'b0 && n < 1000);
      if (rd[LDS_ST_BUSY_BIT] !== 1'b0) stall();
      check(32'(rd[LDS_ST_NACK_BIT]), 32'(nk));
      check(32'(seen), 32'h1);
      // Slave needs a few cycles to see the STOP through its synchroniser
      repeat (4) @(posedge pclk);
      check(32'(link_active), 32'h0);
   endtask
   task automatic sc_reset();
      check(32'({normal_mode, feature_value, dev_select, link_active}), 32'h0);
      check(32'({link.scl, link.sda}), 32'h3);
      apb(1'b0, 8'h08, 32'h0);
      check(32'({err, rd[7:0]}), 32'h100);
   endtask
   task automatic sc_feature();
      xfer(7'h00, 1'b0, feat_cmd, 8'ha5, 1'b0);
      check(32'(feature_value), 32'ha5);
      xfer(7'h00, 1'b1, feat_cmd, 8'h00, 1'b0);
      check(32'(rd[15:8]), 32'ha5);
      xfer(7'h05, 1'b0, feat_cmd, 8'h3c, 1'b1);
      check(32'(feature_value), 32'ha5);
   endtask
   task automatic sc_shutdown();
      logic [7:0] sd [4] = '{8'h01, 8'h00, 8'h81, 8'h80};
      foreach (sd[i]) begin
         xfer(7'h00, 1'b0, feat_cmd, 8'h5a, 1'b0);
         xfer(7'h00, 1'b0, 8'h0c, sd[i], 1'b0);
         check(32'(normal_mode), 32'(sd[i][0]));
         check(32'(feature_value), sd[i][7] ? 32'h5a : 32'h0);
      end
   endtask
   task automatic sc_pin();
      xfer(7'h00, 1'b0, 8'h0c, 8'h81, 1'b0);
      hw_shutdown_pin_n <= 1'b0;
      repeat (6) @(posedge pclk);
      check(32'({normal_mode, feature_value}), 32'h0);
      hw_shutdown_pin_n <= 1'b1;
      repeat (6) @(posedge pclk);
      check(32'(normal_mode), 32'h0);
      xfer(7'h00, 1'b0, 8'h0c, 8'h81, 1'b0);
      check(32'(normal_mode), 32'h1);
   endtask
   task automatic sc_self();
      segment_g_line <= 1'b1;
      repeat (4) @(posedge pclk);
      xfer(7'h00, 1'b0, LDS_CMD_SELF_ADDR, 8'h00, 1'b0);
      check(32'(dev_select), 32'h1);
      xfer(7'h00, 1'b0, feat_cmd, 8'h77, 1'b1);
      xfer(7'h01, 1'b0, feat_cmd, 8'h77, 1'b0);
      check(32'(feature_value), 32'h77);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {hw_shutdown_pin_n, segment_g_line, segment_f_line} = 3'h4;
      mismatches = 0;
      checked = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      sc_reset();
      sc_feature();
      sc_shutdown();
      sc_pin();
      sc_self();
      complete_run();
   end
endmodule
`default_nettype wire
